// >>> rtl/vme_host_interface.sv
// Behaviour
// - As master it drives 24- or 32-bit addresses and moves 16-bit words.
// - As slave it decodes 16- or 24-bit addresses, 8- or 16-bit data.
// - Bus is won by request/grant on sets 0-3, set 3 highest, daisy order.
// - The request level is a static strap, not set by software.
// - Master cycles start only after the bus has been granted and owned.
// - An interrupt asserts the request line of the strapped level.
// - On acknowledge the interrupter puts its 8-bit vector on the bus.
// - If not requesting the acknowledged level, the iack chain passes on.
// - Exactly one interrupt level from 3 to 6 is used; 1, 2, 7 never.
// - A slave hit needs both the address and the modifier to match.
// - Only supervisory data access, standard or short as strapped.
// - The slave base sits on any 16-word boundary of the range.
// - The first fourteen words answer; the last two stay silent.
// - Address bits 24 to 31 are ignored by the slave decoder.
// - Master uses 32 address bits when extended, 24 when standard.
`timescale 1ns/100ps
`default_nettype none
module vme_host_interface (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// board straps
	input wire logic [1:0] req_level,
	input wire logic [2:0] irq_level,
	input wire logic master_a32,
	input wire logic slave_a24,
	input wire logic [23:5] slave_base,
	// arbitration
	output logic [3:0] br_n,
	input wire logic [3:0] bg_in_n,
	output logic [3:0] bg_out_n,
	input wire logic bbusy_in_n,
	output logic bbusy_n,
	// address and modifier
	input wire logic [31:1] a_in,
	output logic [31:1] a_out,
	input wire logic [5:0] am_in,
	output logic [5:0] am_out,
	output logic a_oe_n,
	// strobes
	input wire logic as_in_n,
	input wire logic ds0_in_n,
	input wire logic ds1_in_n,
	input wire logic write_in_n,
	output logic as_out_n,
	output logic ds0_out_n,
	output logic ds1_out_n,
	output logic write_out_n,
	output logic ctl_oe_n,
	// data
	input wire logic [15:0] d_in,
	output logic [15:0] d_out,
	output logic d_oe_n,
	// acknowledge and error
	input wire logic dtack_in_n,
	output logic dtack_out_n,
	output logic dtack_oe_n,
	input wire logic berr_in_n,
	// interrupts
	input wire logic iack_n,
	input wire logic iack_in_n,
	output logic iack_out_n,
	output logic [7:1] irq_n,
	// local master port
	input wire logic mst_req,
	input wire logic mst_write,
	input wire logic [31:0] mst_addr,
	input wire logic [15:0] mst_wdata,
	output logic mst_busy,
	output logic mst_done,
	output logic mst_err,
	output logic [15:0] mst_rdata,
	// local interrupt port
	input wire logic irq_set,
	input wire logic [7:0] irq_vector,
	output logic irq_pending,
	// local register port
	output logic reg_req,
	output logic reg_write,
	output logic [3:0] reg_idx,
	output logic [1:0] reg_be,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	import vme_if_pkg::*;

	function automatic logic [7:0] onehot8(input logic [2:0] n);
		onehot8 = 8'h01 << n;
	endfunction

	mst_state_t st_q;
	logic bbusy_q, as_q, ds_q, mwr_q;
	logic [31:0] maddr_q;
	logic pend_q, ia_ack_q, sl_q, sl_ack_q, done_q, err_q;
	logic [15:0] mdat_q, dout_q, rdat_q;
	logic doe_q, sl_wr_q;
	logic [7:0] br_hot, irq_hot;
	logic hold, irq_ok, our_ack, ia_start, ds_any, ds_idle;
	logic sl_hit, sl_amatch;

	////////////////////////////////////////////////////////////////
	// requester and grant chain
	assign br_hot = onehot8({1'b0, req_level});
	assign hold = st_q != M_IDLE;
	// request only on the strapped level, while waiting
	assign br_n = (st_q == M_REQ) ? ~br_hot[3:0] : 4'hf;
	// pass the grant unless we are requesting or owning
	assign bg_out_n = bg_in_n | (hold ? br_hot[3:0] : 4'h0);
	assign bbusy_n = ~bbusy_q;
	assign mst_busy = hold;

	////////////////////////////////////////////////////////////////
	// master sequencer
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_q <= M_IDLE;
			bbusy_q <= 1'b0;
			as_q <= 1'b0;
			ds_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				M_IDLE: begin
					if (mst_req) begin
						st_q <= M_REQ;
					end
				end
				M_REQ: begin
					// take the bus only when granted and it is free
					if (!bg_in_n[req_level] && bbusy_in_n && as_in_n) begin
						bbusy_q <= 1'b1;
						st_q <= M_ADDR;
					end
				end
				M_ADDR: begin
					as_q <= 1'b1;
					st_q <= M_DATA;
				end
				M_DATA: begin
					ds_q <= 1'b1;
					if (ds_q && (!dtack_in_n || !berr_in_n)) begin
						as_q <= 1'b0;
						ds_q <= 1'b0;
						st_q <= M_END;
					end
				end
				M_END: begin
					// drop ownership once the slave has let go
					if (dtack_in_n && berr_in_n) begin
						bbusy_q <= 1'b0;
						done_q <= 1'b1;
						st_q <= M_IDLE;
					end
				end
				default: st_q <= M_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			maddr_q <= ADDR_RST;
			mdat_q <= DATA_RST;
			mwr_q <= 1'b0;
		end else if (st_q == M_IDLE && mst_req) begin
			// standard addressing keeps the top byte at zero
			maddr_q <= master_a32 ? mst_addr : {8'h00, mst_addr[23:0]};
			mdat_q <= mst_wdata;
			mwr_q <= mst_write;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			rdat_q <= DATA_RST;
			err_q <= 1'b0;
		end else if (st_q == M_DATA && ds_q && (!dtack_in_n || !berr_in_n)) begin
			rdat_q <= d_in;
			err_q <= !berr_in_n;
		end
	end

	assign mst_done = done_q;
	assign mst_err = err_q;
	assign mst_rdata = rdat_q;
	assign a_out = maddr_q[31:1];
	assign am_out = master_a32 ? AM_A32_SD : AM_A24_SD;
	assign a_oe_n = ~bbusy_q;
	assign ctl_oe_n = ~bbusy_q;
	assign as_out_n = ~as_q;
	assign ds0_out_n = ~ds_q;
	assign ds1_out_n = ~ds_q;
	assign write_out_n = ~mwr_q;

	////////////////////////////////////////////////////////////////
	// interrupter
	assign irq_ok = irq_level >= IRQ_MIN && irq_level <= IRQ_MAX;
	assign irq_hot = (pend_q && irq_ok) ? onehot8(irq_level) : 8'h00;
	assign irq_n = ~irq_hot[7:1];
	assign irq_pending = pend_q;
	assign our_ack = pend_q && irq_ok && !iack_n && !as_in_n &&
		a_in[3:1] == irq_level;
	assign ia_start = our_ack && !iack_in_n && !ds0_in_n && !ia_ack_q;
	// pass the chain unless this level is ours
	assign iack_out_n = iack_in_n | our_ack | ia_ack_q;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			pend_q <= 1'b0;
			ia_ack_q <= 1'b0;
		end else begin
			// a new event in the clearing cycle stays pending
			if (irq_set) begin
				pend_q <= 1'b1;
			end else if (ia_start) begin
				pend_q <= 1'b0;
			end
			if (ia_start) begin
				ia_ack_q <= 1'b1;
			end else if (ds0_in_n) begin
				ia_ack_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// slave decoder
	// bits 31..24 never take part in the match
	assign sl_amatch = slave_a24 ? (a_in[23:5] == slave_base) :
		(a_in[15:5] == slave_base[15:5]);
	assign ds_any = !ds0_in_n || !ds1_in_n;
	assign ds_idle = ds0_in_n && ds1_in_n;
	assign sl_hit = !bbusy_q && iack_n && !as_in_n && ds_any &&
		am_in == (slave_a24 ? AM_A24_SD : AM_A16_SD) &&
		sl_amatch && a_in[4:1] < REG_COUNT;

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sl_q <= 1'b0;
			sl_ack_q <= 1'b0;
			reg_req <= 1'b0;
			reg_write <= 1'b0;
			reg_idx <= 4'h0;
			reg_be <= 2'h0;
			reg_wdata <= DATA_RST;
			sl_wr_q <= 1'b0;
		end else begin
			reg_req <= sl_hit && !sl_q;
			if (sl_hit && !sl_q) begin
				sl_q <= 1'b1;
				reg_write <= !write_in_n;
				sl_wr_q <= !write_in_n;
				reg_idx <= a_in[4:1];
				reg_be <= {!ds1_in_n, !ds0_in_n};
				reg_wdata <= d_in;
			end else if (sl_q && ds_idle) begin
				sl_q <= 1'b0;
			end
			if (reg_req) begin
				sl_ack_q <= 1'b1;
			end else if (ds_idle) begin
				sl_ack_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// shared data and acknowledge drivers
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dout_q <= DATA_RST;
			doe_q <= 1'b0;
		end else if (ia_start) begin
			dout_q <= {8'h00, irq_vector};
			doe_q <= 1'b1;
		end else if (reg_req) begin
			dout_q <= reg_rdata;
			doe_q <= !sl_wr_q;
		end else if (st_q == M_ADDR) begin
			dout_q <= mdat_q;
			doe_q <= mwr_q;
		end else if (st_q == M_END || (ds_idle && !bbusy_q)) begin
			doe_q <= 1'b0;
		end
	end

	assign d_out = dout_q;
	assign d_oe_n = ~doe_q;
	assign dtack_out_n = 1'b0;
	assign dtack_oe_n = ~(sl_ack_q | ia_ack_q);

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	sequence s_win;
		st_q == M_REQ && !bg_in_n[req_level] && bbusy_in_n && as_in_n;
	endsequence
	sequence s_cycle;
		st_q == M_ADDR ##1 (st_q == M_DATA && as_q);
	endsequence

	a_bus_owned: assert property (as_q |-> bbusy_q)
		else $error("address strobe without ownership");
	a_grant_start: assert property (s_win |=> s_cycle)
		else $error("cycle did not follow grant");
	a_std_width: assert property (
		(hold && !master_a32) |-> a_out[31:24] == 8'h00)
		else $error("upper address bits set in standard mode");
	a_req_level: assert property (st_q == M_REQ |->
		$onehot(~br_n) && !br_n[req_level])
		else $error("request on wrong level");
	a_grant_pass: assert property (!hold |-> bg_out_n == bg_in_n)
		else $error("idle grant not passed");
	a_irq_level: assert property ($onehot0(~irq_n) && irq_n[1] &&
		irq_n[2] && irq_n[7])
		else $error("illegal interrupt level driven");
	a_irq_drive: assert property (
		(pend_q && irq_ok) |-> !irq_n[irq_level])
		else $error("pending interrupt not driven");
	a_iack_pass: assert property (
		(!iack_in_n && !our_ack && !ia_ack_q) |-> !iack_out_n)
		else $error("acknowledge chain blocked");
	a_vector_out: assert property (ia_start |=>
		(!d_oe_n && d_out[7:0] == $past(irq_vector) && !dtack_oe_n))
		else $error("vector not placed on bus");
	a_slave_map: assert property (reg_req |-> reg_idx < REG_COUNT)
		else $error("reserved word answered");
	a_slave_hit: assert property ($rose(reg_req) |->
		$past(am_in == AM_A24_SD || am_in == AM_A16_SD))
		else $error("hit on wrong modifier");
	a_release: assert property (mst_done |->
		(!bbusy_q && st_q == M_IDLE) ##1 !bbusy_q)
		else $error("bus not released after transfer");
endmodule
`default_nettype wire

// >>> rtl/vme_if_pkg.sv
`default_nettype none
package vme_if_pkg;
	// address modifier codes, supervisory data spaces
	localparam logic [5:0] AM_A32_SD = 6'h0d;
	localparam logic [5:0] AM_A24_SD = 6'h3d;
	localparam logic [5:0] AM_A16_SD = 6'h2d;
	// decoded registers in the 16-word window
	localparam logic [3:0] REG_COUNT = 4'he;
	// interrupt levels that may be strapped
	localparam logic [2:0] IRQ_MIN = 3'h3;
	localparam logic [2:0] IRQ_MAX = 3'h6;
	// reset values
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	typedef enum logic [2:0] {
		M_IDLE, M_REQ, M_ADDR, M_DATA, M_END
	} mst_state_t;
endpackage
`default_nettype wire

// >>> tb/backplane_model.sv
`timescale 1ns/100ps
`default_nettype none
module backplane_model #(
	parameter logic [15:0] RD = 16'h5ac3
) (
	// clock and straps
	input wire logic ref_clk,
	input wire logic [1:0] lvl,
	input wire logic [3:0] dly,
	input wire logic spur,
	// lines from the board
	input wire logic [3:0] br_n,
	input wire logic bbusy_n,
	input wire logic ds0_out_n,
	// lines to the board
	output logic [3:0] bg_in_n,
	output logic dtack_in_n,
	output logic [15:0] d_in
);
	logic [3:0] gc_q = 4'h0;
	logic [3:0] dc_q = 4'h0;
	logic [15:0] dq_q = 16'h0f0f;
	logic gnt;
	always_ff @(posedge ref_clk) begin
		gc_q <= br_n[lvl] ? 4'h0 : gc_q + 4'h1;
		dc_q <= ds0_out_n ? 4'h0 : dc_q + 4'h1;
		dq_q <= ~d_in;
	end
	// grant only on the requested set, after the chosen wait, or at once while spur is set
	assign gnt = (!br_n[lvl] && gc_q >= dly && bbusy_n) || spur;
	assign bg_in_n = ~(4'(gnt) << lvl);
	assign dtack_in_n = !(!ds0_out_n && dc_q >= dly);
	// released data lines toggle rather than hold
	assign d_in = dtack_in_n ? dq_q : RD;
endmodule
`default_nettype wire

// >>> tb/vme_host_interface_test.sv
`timescale 1ns/100ps
`default_nettype none
module vme_host_interface_test;
	import vme_if_pkg::*;
	localparam logic [15:0] RD = 16'h5ac3;
	localparam logic [15:0] RR = 16'h3c5a;
	localparam logic [23:0] BASE = 24'h5aa3e0;
	logic ref_clk = 1'b0, resetn = 1'b0;
	logic [1:0] req_level = 2'h0;
	logic [2:0] irq_level = 3'h3;
	logic master_a32 = 1'b0, slave_a24 = 1'b1, spur = 1'b0;
	logic [31:1] a_in = 31'h0, a_out;
	logic [5:0] am_in = 6'h0, am_out;
	logic as_in_n = 1'b1, ds0_in_n = 1'b1, ds1_in_n = 1'b1;
	logic write_in_n = 1'b1, iack_n = 1'b1, iack_in_n = 1'b1;
	logic berr_in_n = 1'b1, mst_req = 1'b0, mst_write = 1'b0, irq_set = 1'b0;
	logic [31:0] mst_addr = 32'h0;
	logic [15:0] mst_wdata = 16'h0, tb_d = 16'h0, reg_rdata = RR;
	logic [15:0] d_out, mst_rdata, reg_wdata, p_d;
	logic [7:0] irq_vector = 8'h0;
	logic [3:0] dly = 4'h0, br_n, bg_in_n, bg_out_n, reg_idx;
	logic bbusy_n, a_oe_n, as_out_n, ds0_out_n, d_oe_n, dtack_in_n;
	logic dtack_oe_n, iack_out_n, mst_done, mst_err, reg_req, reg_write;
	logic [7:1] irq_n;
	logic ds1_out_n, write_out_n, ctl_oe_n, dtack_out_n, mst_busy, irq_pending;
	logic [1:0] reg_be;
	wire [15:0] d_in;
	wire bbusy_in_n;
	int err_total = 0, n_checks = 0;
	assign d_in = as_in_n ? p_d : tb_d;
	assign bbusy_in_n = bbusy_n;
	always #25 ref_clk = ~ref_clk;
	vme_host_interface dut (.*, .slave_base(BASE[23:5]));
	backplane_model #(.RD(RD)) bus (.*, .lvl(req_level), .d_in(p_d));
	////////////////////////////////////////////////////////////////////////
	task automatic tick;
		@(posedge ref_clk);
		#5;
	endtask
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// a bounded wait that ran out ends the run
	task automatic hang(input logic ok, input string m);
		chk(ok, m);
		if (ok !== 1'b1) stop_test;
	endtask
	task automatic mt(input int l, input logic a32, input logic wr,
		input logic [31:0] ad, input logic [15:0] wd, input logic [3:0] dl);
		int i;
		req_level = l[1:0];
		master_a32 = a32;
		dly = dl;
		mst_write = wr;
		mst_addr = ad;
		mst_wdata = wd;
		mst_req = 1'b1;
		tick;
		mst_req = 1'b0;
		chk(br_n === ~(4'h1 << l), "request set");
		chk(bg_out_n === 4'hf && mst_busy === 1'b1, "grant kept");
		chk(as_out_n === 1'b1, "strobe before grant");
		for (i = 0; i < 40 && ds0_out_n !== 1'b0; i++) tick;
		hang(ds0_out_n === 1'b0, "no data strobe");
		chk(bbusy_n === 1'b0 && br_n === 4'hf, "ownership");
		chk(ds1_out_n === 1'b0 && write_out_n === ~wr, "strobes");
		chk(a_oe_n === 1'b0 && ctl_oe_n === 1'b0, "drivers on");
		chk(am_out === (a32 ? AM_A32_SD : AM_A24_SD), "modifier");
		chk(a32 ? a_out === ad[31:1] : a_out[23:1] === ad[23:1], "addr");
		if (wr) chk(d_out === wd && d_oe_n === 1'b0, "write data");
		for (i = 0; i < 40 && mst_done !== 1'b1; i++) tick;
		hang(mst_done === 1'b1, "no done");
		if (!wr) chk(mst_rdata === RD && mst_err === 1'b0, "read data");
		chk(bbusy_n === 1'b1 && a_oe_n === 1'b1, "release");
		chk(ctl_oe_n === 1'b1 && mst_busy === 1'b0, "drivers off");
		tick;
		chk(mst_done === 1'b0 && br_n === 4'hf, "idle again");
	endtask
	task automatic it(input logic [2:0] lv, input logic [7:0] v);
		int i;
		irq_level = lv;
		irq_vector = v;
		irq_set = 1'b1;
		tick;
		irq_set = 1'b0;
		if (lv < IRQ_MIN || lv > IRQ_MAX) begin
			chk(irq_n === 7'h7f, "level not usable");
			return;
		end
		chk(irq_n === ~(7'h1 << (lv - 3'h1)), "request line");
		chk(irq_pending === 1'b1, "pending");
		iack_n = 1'b0;
		iack_in_n = 1'b0;
		as_in_n = 1'b0;
		ds0_in_n = 1'b0;
		a_in[3:1] = lv ^ 3'h1;
		tick;
		chk(iack_out_n === 1'b0 && dtack_oe_n === 1'b1, "chain pass");
		a_in[3:1] = lv;
		for (i = 0; i < 3 && dtack_oe_n !== 1'b0; i++) tick;
		hang(dtack_oe_n === 1'b0, "no vector");
		chk(d_out === {8'h00, v} && d_oe_n === 1'b0, "vector");
		chk(iack_out_n === 1'b1 && dtack_out_n === 1'b0, "chain held");
		iack_n = 1'b1;
		iack_in_n = 1'b1;
		as_in_n = 1'b1;
		ds0_in_n = 1'b1;
		tick;
		tick;
		chk(dtack_oe_n === 1'b1 && irq_n === 7'h7f, "ack end");
		chk(irq_pending === 1'b0, "pending cleared");
	endtask
	task automatic sl(input logic a24, input logic [5:0] am,
		input logic [31:0] ad, input logic wr, input logic [1:0] dn,
		input logic hit);
		int i;
		slave_a24 = a24;
		am_in = am;
		a_in = ad[31:1];
		write_in_n = ~wr;
		tb_d = 16'h96e1 ^ ad[15:0];
		as_in_n = 1'b0;
		{ds1_in_n, ds0_in_n} = dn;
		for (i = 0; i < 4 && reg_req !== 1'b1; i++) tick;
		chk(reg_req === hit, "decode");
		if (hit) begin
			chk(reg_idx === ad[4:1] && reg_write === wr, "index");
			chk(reg_be === ~dn, "lanes");
			if (wr) chk(reg_wdata === tb_d, "write");
			tick;
			chk(dtack_oe_n === 1'b0, "ack");
			if (!wr) chk(d_out === RR && d_oe_n === 1'b0, "read");
		end else chk(dtack_oe_n === 1'b1, "silent");
		as_in_n = 1'b1;
		{ds1_in_n, ds0_in_n} = 2'b11;
		tick;
		tick;
		chk(dtack_oe_n === 1'b1, "ack drop");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge ref_clk);
		#5;
		chk(br_n === 4'hf && bbusy_n === 1'b1 && irq_n === 7'h7f, "reset");
		resetn = 1'b1;
		for (int i = 0; i < 4; i++) begin
			mt(i, i[0], i[1], 32'h8765_4320 + 32'(i * 6),
				16'h1111 * 16'(i + 1), 4'(i * 3));
		end
		spur = 1'b1;
		req_level = 2'h2;
		tick;
		chk(bg_out_n === 4'b1011, "grant pass");
		spur = 1'b0;
		it(3'h2, 8'h21);
		it(3'h7, 8'h27);
		for (int i = 3; i < 7; i++) it(i[2:0], 8'h40 + 8'(i));
		sl(1'b1, AM_A24_SD, {8'h00, BASE}, 1'b0, 2'b00, 1'b1);
		sl(1'b1, AM_A24_SD, {8'hff, BASE} + 32'h1a, 1'b1, 2'b10, 1'b1);
		sl(1'b1, AM_A24_SD, {8'h00, BASE} + 32'h1c, 1'b0, 2'b00, 1'b0);
		sl(1'b1, AM_A24_SD, {8'h00, BASE} + 32'h1e, 1'b0, 2'b00, 1'b0);
		sl(1'b1, 6'h39, {8'h00, BASE}, 1'b0, 2'b00, 1'b0);
		sl(1'b1, AM_A32_SD, {8'h00, BASE}, 1'b0, 2'b00, 1'b0);
		sl(1'b1, AM_A24_SD, {8'h00, BASE} + 32'h20, 1'b0, 2'b00, 1'b0);
		sl(1'b0, AM_A16_SD, {16'h0, BASE[15:0]} + 32'h4, 1'b0, 2'b01, 1'b1);
		sl(1'b0, AM_A24_SD, {16'h0, BASE[15:0]}, 1'b0, 2'b00, 1'b0);
		stop_test;
	end
endmodule
`default_nettype wire
